// File: dv/uart_fc_host.sv
`timescale 1ns/1ps
module uart_fc_host #(
	parameter int BIT = 20
) (
	input  wire clk_sys_i,
	input  wire tx_line_i,
	input  wire rts_n_i,
	output reg  rx_line_o
);
	initial rx_line_o = 1'b1;
	task automatic bit_out(input logic v);
		rx_line_o = v;
		repeat (BIT) @(negedge clk_sys_i);
	endtask
	// Bad: bit 0 flips parity, bit 1 lowers part of the stop bit
	task automatic send(input logic [7:0] d, input logic pe, po,
		input logic [1:0] bad);
		int i;
		for (i = 0; i < 9999 && rts_n_i !== 1'b0; i++) @(negedge clk_sys_i);
		bit_out(1'b0);
		for (i = 0; i < 8; i++) bit_out(d[i]);
		if (pe) bit_out(^d ^ po ^ bad[0]);
		if (bad[1]) begin
			rx_line_o = 1'b0;
			repeat (BIT * 3 / 4) @(negedge clk_sys_i);
		end
		bit_out(1'b1);
		bit_out(1'b1);
	endtask
	task automatic recv(input logic pe, output logic [7:0] d,
		output logic p, s);
		int i;
		for (i = 0; i < 20000 && tx_line_i !== 1'b0; i++) @(negedge clk_sys_i);
		repeat (BIT / 2) @(negedge clk_sys_i);
		for (i = 0; i < 8; i++) begin
			repeat (BIT) @(negedge clk_sys_i);
			d[i] = tx_line_i;
		end
		p = 1'b0;
		if (pe) begin
			repeat (BIT) @(negedge clk_sys_i);
			p = tx_line_i;
		end
		repeat (BIT) @(negedge clk_sys_i);
		s = tx_line_i;
	endtask
endmodule

// File: dv/uart_fc_properties.sv
`timescale 1ns/1ps
module uart_fc_properties (
	input wire        clk_sys_i,
	input wire        rst_n_i,
	input wire [15:0] baud_div_i,
	input wire        flow_en_i,
	input wire        tx_ready_o,
	input wire [7:0]  rx_data_o,
	input wire        rx_valid_o,
	input wire        rx_ready_i,
	input wire        port_pin_six_o,
	input wire        port_pin_six_oe_o,
	input wire        port_pin_eight_pu_o,
	input wire        port_pin_five_o,
	input wire        port_pin_five_oe_o,
	input wire        port_pin_seven_i,
	input wire        port_pin_seven_pd_o
);
	reg  [31:0] hi_q;
	wire [15:0] bit_w = (baud_div_i < 16'h0014) ? 16'h0014 : baud_div_i;
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			hi_q <= 32'h0;
		else
			hi_q <= port_pin_six_o ? hi_q + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_bit_low;
		!port_pin_six_o [*8];
	endsequence
	sequence s_cts_off;
		(flow_en_i && port_pin_seven_i) [*6];
	endsequence
	a_pin_dirs: assert property (
		port_pin_six_oe_o && port_pin_five_oe_o) else $error("oe low");
	a_pin_pulls: assert property (
		port_pin_eight_pu_o && port_pin_seven_pd_o) else $error("pull off");
	a_rts_flow_off: assert property (
		!flow_en_i [*2] |-> !port_pin_five_o) else $error("rts high");
	a_start_width: assert property (
		$fell(port_pin_six_o) |-> s_bit_low) else $error("short low");
	a_mark_width: assert property (
		$rose(port_pin_six_o) |-> port_pin_six_o [*8]) else $error("short high");
	a_rx_hold: assert property (
		rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
		else $error("rx dropped");
	a_cts_blocks: assert property (
		s_cts_off ##0 (hi_q > 32'hB * bit_w) |=> port_pin_six_o)
		else $error("tx while cts off");
	a_reset_state: assert property (
		$rose(rst_n_i) |-> port_pin_six_o && !port_pin_five_o && tx_ready_o
		&& !rx_valid_o) else $error("reset state");
endmodule

// File: dv/uart_with_flow_control_test.sv
`timescale 1ns/1ps
module uart_with_flow_control_test;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         pe = 1'b0;
	reg         po = 1'b0;
	reg         two = 1'b0;
	reg         fl = 1'b0;
	reg         txv = 1'b0;
	reg         rxr = 1'b0;
	reg         cts_n = 1'b0;
	reg  [7:0]  txd = 8'h00;
	reg  [15:0] bd = 16'h0014;
	wire [7:0]  rxd;
	wire        txr, rxv, perr, ferr, txl, oe6, hrx, pu8, rts_n, oe5, pd7;
	wire        ovr;
	logic [7:0] d;
	logic       p, s;
	int         fails = 0;
	int         comparisons = 0;
	always #25 clk = ~clk;
	uart_with_flow_control uart_with_flow_control_inst (
		.clk_sys_i(clk), .rst_n_i(rst_n), .baud_div_i(bd),
		.parity_en_i(pe), .parity_odd_i(po), .two_stop_i(two),
		.flow_en_i(fl), .tx_data_i(txd), .tx_valid_i(txv),
		.tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv),
		.rx_ready_i(rxr), .rx_parity_err_o(perr), .rx_frame_err_o(ferr),
		.rx_overrun_o(ovr), .port_pin_six_o(txl), .port_pin_six_oe_o(oe6),
		.port_pin_eight_i(hrx), .port_pin_eight_pu_o(pu8),
		.port_pin_five_o(rts_n), .port_pin_five_oe_o(oe5),
		.port_pin_seven_i(cts_n), .port_pin_seven_pd_o(pd7));
	uart_fc_host #(.BIT(20)) uart_fc_host_inst (.clk_sys_i(clk),
		.tx_line_i(txl), .rts_n_i(rts_n), .rx_line_o(hrx));
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task push(input logic [7:0] v);
		int i;
		@(negedge clk);
		txd = v;
		txv = 1'b1;
		for (i = 0; i < 5000 && txr !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		txv = 1'b0;
	endtask
	task pop(input logic [7:0] v, input logic pb, fb);
		int i;
		@(negedge clk);
		for (i = 0; i < 5000 && rxv !== 1'b1; i++) @(negedge clk);
		chk("rx_data", v, rxd);
		chk("rx_errors", {6'h0, pb, fb}, {6'h0, perr, ferr});
		rxr = 1'b1;
		@(negedge clk);
		rxr = 1'b0;
	endtask
	task t_reset;
		chk("pins", 8'hBE, {txl, rts_n, oe6, oe5, pu8, pd7, txr, rxv});
	endtask
	task t_tx;
		logic [7:0] e;
		int         m;
		e = 8'hA6;
		for (m = 0; m < 3; m++) begin
			bd = (m == 1) ? 16'h0005 : 16'h0014;
			pe = (m != 0);
			po = (m == 2);
			push(e);
			uart_fc_host_inst.recv(pe, d, p, s);
			chk("tx_data", e, d);
			chk("tx_frame", {6'h0, pe & (^e ^ po), 1'b1}, {6'h0, p, s});
			e = e + 8'h11;
		end
		two = 1'b1;
		push(e);
		push(e);
		uart_fc_host_inst.recv(pe, d, p, s);
		chk("tx_data2", e, d);
		repeat (20) @(negedge clk);
		chk("tx_stop2", 8'h01, {7'h0, txl});
		uart_fc_host_inst.recv(pe, d, p, s);
		chk("tx_data2", e, d);
		two = 1'b0;
	endtask
	task t_rx;
		int m;
		for (m = 0; m < 3; m++) begin
			pe = (m < 2);
			po = (m == 1);
			uart_fc_host_inst.send(8'h3C ^ 8'(m), pe, po, 2'(m));
			pop(8'h3C ^ 8'(m), m == 1, m == 2);
		end
	endtask
	task t_flow;
		int m;
		fl = 1'b1;
		pe = 1'b0;
		for (m = 0; m < 6; m++) begin
			if (m == 4)
				fl = 1'b0;
			uart_fc_host_inst.send(8'h50 + 8'(m), 1'b0, 1'b0, 2'b00);
			if (m == 3)
				chk("rts_full", 8'h01, {7'h0, rts_n});
		end
		chk("overrun", 8'h01, {7'h0, ovr});
		fl = 1'b1;
		for (m = 0; m < 5; m++) pop(8'h50 + 8'(m), 1'b0, 1'b0);
		chk("overrun_clr", 8'h00, {7'h0, ovr});
		chk("rts_free", 8'h00, {7'h0, rts_n});
		cts_n = 1'b1;
		repeat (4) @(negedge clk);
		for (m = 0; m < 4; m++) push(8'h60 + 8'(m));
		repeat (40) @(negedge clk);
		chk("cts_hold", 8'h02, {6'h0, txl, txr});
		cts_n = 1'b0;
		for (m = 0; m < 4; m++) begin
			uart_fc_host_inst.recv(1'b0, d, p, s);
			chk("tx_flow", 8'h60 + 8'(m), d);
		end
		fl = 1'b0;
	endtask
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset;
		t_tx;
		t_rx;
		t_flow;
		wrap_up;
	end
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		wrap_up;
	end
endmodule
bind uart_with_flow_control uart_fc_properties uart_fc_properties_inst (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .baud_div_i(baud_div_i),
	.flow_en_i(flow_en_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
	.rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
	.port_pin_six_o(port_pin_six_o), .port_pin_six_oe_o(port_pin_six_oe_o),
	.port_pin_eight_pu_o(port_pin_eight_pu_o),
	.port_pin_five_o(port_pin_five_o), .port_pin_five_oe_o(port_pin_five_oe_o),
	.port_pin_seven_i(port_pin_seven_i),
	.port_pin_seven_pd_o(port_pin_seven_pd_o));

// File: logic/uart_fc_fifo.v
`timescale 1ns/1ps
module uart_fc_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk_sys_i,
	input  wire             rst_n_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [AW:0]      level_o
);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      cnt_q;
	reg [AW:0]      cnt_d;
	reg             rdy_q;
	wire            push;
	wire            pop;

	assign in_ready_o  = rdy_q;
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem_q[rd_ptr_q];
	assign level_o     = cnt_q;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @(posedge clk_sys_i) begin
		if (push)
			mem_q[wr_ptr_q] <= in_data_i;
	end

	always @* begin
		cnt_d = cnt_q;
		if (push & ~pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop & ~push)
			cnt_d = cnt_q - 1'b1;
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q    <= {(AW+1){1'b0}};
			rdy_q    <= 1'b1;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			cnt_q <= cnt_d;
			rdy_q <= (cnt_d != DEPTH[AW:0]);
		end
	end

endmodule

// File: logic/uart_fc_regs.vh
`ifndef UART_FC_REGS_VH
`define UART_FC_REGS_VH

// Clock and line rate
`define CLK_HZ          20000000
`define MAX_BAUD        1000000
`define DEF_BAUD        115200
// Divider width and default divisor (clocks per bit)
`define DIV_W           16
`define DEF_DIV         16'h00AD
`define MIN_DIV         16'h0014
// Character width
`define DATA_W          8
`define BIT_CNT_W       4
// FIFO shape
`define FIFO_DEPTH      4
`define FIFO_AW         2
// Receive FIFO level at which ready to send is withdrawn
`define RTS_STOP_LVL    3'h3
// Line levels
`define LINE_IDLE       1'b1
`define LINE_START      1'b0
`define HS_ASSERT       1'b0
`define HS_DEASSERT     1'b1

`endif

// File: logic/uart_fc_sync.v
`timescale 1ns/1ps
module uart_fc_sync #(
	parameter WIDTH = 2
) (
	input  wire             clk_sys_i,
	input  wire             rst_n_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);

	// ----------------------------------------------------------------
	// Two-stage synchronisers, idle-high reset
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			always @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
				end else begin
					meta_q <= async_i[g];
					sync_q <= meta_q;
				end
			end
			assign sync_o[g] = sync_q;
		end
	endgenerate

endmodule

// File: logic/uart_with_flow_control.v
`timescale 1ns/1ps
`include "uart_fc_regs.vh"

// Overview of operation
// - Full-duplex serial port, divisor down to one megabit, flow control in hardware.
// - With parity on, send ninth-bit parity and check it on every character.
// - Drive ready-to-send out, sample clear-to-send in, both active low.
// - Low on a handshake line means asserted, high means deasserted.
// - Transmit and receive lines rest high when no character moves.
// - Transmit pin is an output driven high after reset.
// - Receive pin is an input with pull-up; undriven reads idle.
// - Ready-to-send pin is an output driven low after reset.
// - Clear-to-send pin is an input with pull-down; open reads asserted.
// - Framing and handshake match a conventional host serial port.
module uart_with_flow_control (
	input  wire                clk_sys_i,
	input  wire                rst_n_i,
	input  wire [`DIV_W-1:0]   baud_div_i,
	input  wire                parity_en_i,
	input  wire                parity_odd_i,
	input  wire                two_stop_i,
	input  wire                flow_en_i,
	input  wire [`DATA_W-1:0]  tx_data_i,
	input  wire                tx_valid_i,
	output wire                tx_ready_o,
	output reg  [`DATA_W-1:0]  rx_data_o,
	output reg                 rx_valid_o,
	input  wire                rx_ready_i,
	output reg                 rx_parity_err_o,
	output reg                 rx_frame_err_o,
	output reg                 rx_overrun_o,
	output reg                 port_pin_six_o,
	output reg                 port_pin_six_oe_o,
	input  wire                port_pin_eight_i,
	output reg                 port_pin_eight_pu_o,
	output reg                 port_pin_five_o,
	output reg                 port_pin_five_oe_o,
	input  wire                port_pin_seven_i,
	output reg                 port_pin_seven_pd_o
);

	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam ST_IDLE   = 3'h0;
	localparam ST_START  = 3'h1;
	localparam ST_DATA   = 3'h2;
	localparam ST_PAR    = 3'h3;
	localparam ST_STOP   = 3'h4;
	localparam ST_STOP2  = 3'h5;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire [1:0] pins_sync;
	wire       rx_line;
	wire       cts_line;

	uart_fc_sync #(
		.WIDTH   (2)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   ({port_pin_seven_i, port_pin_eight_i}),
		.sync_o    (pins_sync)
	);
	assign rx_line  = pins_sync[0];
	assign cts_line = pins_sync[1];

	// Clamp divisor to the fastest legal rate
	wire [`DIV_W-1:0] div;
	assign div = (baud_div_i < `MIN_DIV) ? `MIN_DIV : baud_div_i;

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	wire [`DATA_W-1:0] txf_data;
	wire               txf_valid;
	reg                txf_pop;

	uart_fc_fifo #(
		.WIDTH (`DATA_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_tx_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (tx_data_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.out_data_o  (txf_data),
		.out_valid_o (txf_valid),
		.out_ready_i (txf_pop),
		.level_o     ()
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	reg [2:0]            tx_st_q;
	reg [`DIV_W-1:0]     tx_cnt_q;
	reg [`BIT_CNT_W-1:0] tx_bit_q;
	reg [`DATA_W-1:0]    tx_sh_q;
	reg                  tx_par_q;
	wire                 tx_tick;
	wire                 cts_ok;

	assign tx_tick = (tx_cnt_q == {`DIV_W{1'b0}});
	assign cts_ok  = ~flow_en_i | (cts_line == `HS_ASSERT);

	always @* begin
		txf_pop = (tx_st_q == ST_IDLE) & txf_valid & cts_ok;
	end

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_st_q        <= ST_IDLE;
			tx_cnt_q       <= {`DIV_W{1'b0}};
			tx_bit_q       <= {`BIT_CNT_W{1'b0}};
			tx_sh_q        <= {`DATA_W{1'b0}};
			tx_par_q       <= 1'b0;
			port_pin_six_o <= `LINE_IDLE;
		end else begin
			tx_cnt_q <= tx_tick ? div - 1'b1 : tx_cnt_q - 1'b1;
			case (tx_st_q)
			ST_IDLE: begin
				port_pin_six_o <= `LINE_IDLE;
				tx_cnt_q       <= div - 1'b1;
				if (txf_pop) begin
					tx_sh_q        <= txf_data;
					tx_par_q       <= ^txf_data ^ parity_odd_i;
					port_pin_six_o <= `LINE_START;
					tx_st_q        <= ST_START;
				end
			end
			ST_START: begin
				if (tx_tick) begin
					port_pin_six_o <= tx_sh_q[0];
					tx_sh_q        <= tx_sh_q >> 1;
					tx_bit_q       <= {`BIT_CNT_W{1'b0}};
					tx_st_q        <= ST_DATA;
				end
			end
			ST_DATA: begin
				if (tx_tick) begin
					if (tx_bit_q == `DATA_W - 1) begin
						if (parity_en_i) begin
							port_pin_six_o <= tx_par_q;
							tx_st_q        <= ST_PAR;
						end else begin
							port_pin_six_o <= `LINE_IDLE;
							tx_st_q        <= ST_STOP;
						end
					end else begin
						port_pin_six_o <= tx_sh_q[0];
						tx_sh_q        <= tx_sh_q >> 1;
						tx_bit_q       <= tx_bit_q + 1'b1;
					end
				end
			end
			ST_PAR: begin
				if (tx_tick) begin
					port_pin_six_o <= `LINE_IDLE;
					tx_st_q        <= ST_STOP;
				end
			end
			ST_STOP: begin
				if (tx_tick)
					tx_st_q <= two_stop_i ? ST_STOP2 : ST_IDLE;
			end
			ST_STOP2: begin
				if (tx_tick)
					tx_st_q <= ST_IDLE;
			end
			default: begin
				tx_st_q        <= ST_IDLE;
				port_pin_six_o <= `LINE_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	reg [2:0]            rx_st_q;
	reg [`DIV_W-1:0]     rx_cnt_q;
	reg [`BIT_CNT_W-1:0] rx_bit_q;
	reg [`DATA_W-1:0]    rx_sh_q;
	reg                  rx_par_q;
	reg                  rxf_push;
	reg  [`DATA_W+1:0]   rxf_in;
	wire [`DATA_W+1:0]   rxf_out;
	wire                 rxf_valid;
	wire                 rxf_ready;
	wire [`FIFO_AW:0]    rxf_level;
	wire                 rx_tick;
	wire                 rxf_pop;

	assign rx_tick = (rx_cnt_q == {`DIV_W{1'b0}});

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_st_q      <= ST_IDLE;
			rx_cnt_q     <= {`DIV_W{1'b0}};
			rx_bit_q     <= {`BIT_CNT_W{1'b0}};
			rx_sh_q      <= {`DATA_W{1'b0}};
			rx_par_q     <= 1'b0;
			rxf_push     <= 1'b0;
			rxf_in       <= {(`DATA_W+2){1'b0}};
			rx_overrun_o <= 1'b0;
		end else begin
			rxf_push <= 1'b0;
			// Pop clears overrun, a new overrun below wins
			if (rxf_pop)
				rx_overrun_o <= 1'b0;
			rx_cnt_q <= rx_tick ? div - 1'b1 : rx_cnt_q - 1'b1;
			case (rx_st_q)
			ST_IDLE: begin
				rx_cnt_q <= {1'b0, div[`DIV_W-1:1]};
				if (rx_line == `LINE_START)
					rx_st_q <= ST_START;
			end
			ST_START: begin
				if (rx_tick) begin
					rx_bit_q <= {`BIT_CNT_W{1'b0}};
					rx_st_q  <= (rx_line == `LINE_START) ? ST_DATA
					                                     : ST_IDLE;
				end
			end
			ST_DATA: begin
				if (rx_tick) begin
					rx_sh_q  <= {rx_line, rx_sh_q[`DATA_W-1:1]};
					rx_bit_q <= rx_bit_q + 1'b1;
					if (rx_bit_q == `DATA_W - 1)
						rx_st_q <= parity_en_i ? ST_PAR : ST_STOP;
				end
			end
			ST_PAR: begin
				if (rx_tick) begin
					rx_par_q <= rx_line;
					rx_st_q  <= ST_STOP;
				end
			end
			ST_STOP: begin
				if (rx_tick) begin
					rxf_in[`DATA_W-1:0] <= rx_sh_q;
					rxf_in[`DATA_W]     <= parity_en_i &
						(rx_par_q != (^rx_sh_q ^ parity_odd_i));
					rxf_in[`DATA_W+1]   <= (rx_line != `LINE_IDLE);
					rxf_push            <= 1'b1;
					if (!rxf_ready)
						rx_overrun_o <= 1'b1;
					rx_st_q <= ST_IDLE;
				end
			end
			default: rx_st_q <= ST_IDLE;
			endcase
		end
	end

	uart_fc_fifo #(
		.WIDTH (`DATA_W + 2),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_rx_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (rxf_in),
		.in_valid_i  (rxf_push),
		.in_ready_o  (rxf_ready),
		.out_data_o  (rxf_out),
		.out_valid_o (rxf_valid),
		.out_ready_i (rxf_pop),
		.level_o     (rxf_level)
	);

	// ----------------------------------------------------------------
	// Receive output register
	// ----------------------------------------------------------------
	assign rxf_pop = rxf_valid & (~rx_valid_o | rx_ready_i);

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_data_o       <= {`DATA_W{1'b0}};
			rx_valid_o      <= 1'b0;
			rx_parity_err_o <= 1'b0;
			rx_frame_err_o  <= 1'b0;
		end else if (rxf_pop) begin
			rx_data_o       <= rxf_out[`DATA_W-1:0];
			rx_parity_err_o <= rxf_out[`DATA_W];
			rx_frame_err_o  <= rxf_out[`DATA_W+1];
			rx_valid_o      <= 1'b1;
		end else if (rx_ready_i) begin
			rx_valid_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Handshake and pin configuration
	// ----------------------------------------------------------------
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_pin_five_o     <= `HS_ASSERT;
			port_pin_five_oe_o  <= 1'b1;
			port_pin_six_oe_o   <= 1'b1;
			port_pin_eight_pu_o <= 1'b1;
			port_pin_seven_pd_o <= 1'b1;
		end else begin
			port_pin_five_oe_o  <= 1'b1;
			port_pin_six_oe_o   <= 1'b1;
			port_pin_eight_pu_o <= 1'b1;
			port_pin_seven_pd_o <= 1'b1;
			// Withdraw ready-to-send while one slot left
			port_pin_five_o <= (flow_en_i &&
				rxf_level >= `RTS_STOP_LVL) ? `HS_DEASSERT : `HS_ASSERT;
		end
	end

endmodule
